// ---- src/spsg_top.v ----
// Power-down sequencer with strap latching, control-port pin muxing and mirror output.
`timescale 1ns/100ps
`default_nettype none
`include "spsg_regs.vh"
module spsg_top
#(
    parameter NSTRAP = 2,
    parameter SETTLE_CYC = `SPSG_STRAP_SETTLE_CYC
)
(
    // Clock and reset
    input wire i_clock,
    input wire i_reset_n,

    // Power-down pin
    input wire i_power_down_n,
    output wire o_power_down,

    // Configuration straps, sensed under a weak pull-up and a weak pull-down
    input wire [NSTRAP-1:0] i_config_straps_pu,
    input wire [NSTRAP-1:0] i_config_straps_pd,
    output wire [1:0] o_config_strap_0,
    output wire [1:0] o_config_strap_1,
    output wire o_control_mode,

    // Control-port pin 0 (receive or SDA), open drain
    input wire i_ctrl_pin0,
    output wire o_ctrl_pin0,
    output wire o_ctrl_pin0_oe,

    // Control-port pin 1 (transmit or SCL), open drain
    input wire i_ctrl_pin1,
    output wire o_ctrl_pin1,
    output wire o_ctrl_pin1_oe,

    // Internal UART side
    input wire i_uart_tx,
    output wire o_uart_rx,

    // Internal I2C side
    input wire i_i2c_sda_pull_low,
    input wire i_i2c_scl_pull_low,
    output wire o_i2c_sda,
    output wire o_i2c_scl,

    // Line fault monitor and open-drain fault pin
    input wire i_line_monitor_in_0,
    input wire i_line_monitor_in_1,
    output wire o_line_fault_n,
    output wire o_line_fault_n_oe,

    // Shared strap / mirror pin
    input wire i_shared_pin,
    output wire o_shared_pin,
    output wire o_shared_pin_oe,

    // Remote general input level, as carried over the link
    input wire i_remote_general_in,
    output wire o_remote_mirror_out,

    // High-immunity bit and its register write
    input wire i_immunity_wr_en,
    input wire i_immunity_wr_data,
    output wire o_high_immunity_bit,
    output wire o_ready
);
    localparam ST_POWERUP = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_DOWN = 2'h2;
    localparam ST_WAKE = 2'h3;
    localparam CW = 8;
    localparam integer SETTLE_LAST_I = SETTLE_CYC - 1;
    localparam [CW-1:0] SETTLE_LAST = SETTLE_LAST_I[CW-1:0];

    // Synchronised pin levels.
    wire power_down_n_sync;
    wire [NSTRAP-1:0] strap_pu_sync;
    wire [NSTRAP-1:0] strap_pd_sync;
    wire pin0_sync;
    wire pin1_sync;
    wire fault_sync_0;
    wire fault_sync_1;
    wire shared_sync;

    // Sequencer state.
    reg [1:0] state;
    reg [1:0] next_state;
    reg [CW-1:0] settle_count;
    reg [CW-1:0] next_settle_count;
    reg settle_done;

    // Latched straps and derived bits.
    wire [1:0] strap_code [0:NSTRAP-1];
    reg [1:0] strap_0;
    reg [1:0] strap_1;
    reg mode;
    reg immunity;
    reg mirror;
    reg fault;
    reg powered_down;

    // The power-down sync resets to low so the block comes up powered down.
    spsg_sync #(.W(1), .RST_VAL(1'b0)) u_sync_power_down
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async(i_power_down_n),
        .o_sync(power_down_n_sync)
    );

    spsg_sync #(.W(2 * NSTRAP)) u_sync_straps
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async({i_config_straps_pu, i_config_straps_pd}),
        .o_sync({strap_pu_sync, strap_pd_sync})
    );

    // Idle control lines and the shared pin's pull-down default set the reset levels.
    spsg_sync #(.W(5), .RST_VAL(5'h18)) u_sync_pins
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async({i_ctrl_pin0, i_ctrl_pin1, i_line_monitor_in_0, i_line_monitor_in_1, i_shared_pin}),
        .o_sync({pin0_sync, pin1_sync, fault_sync_0, fault_sync_1, shared_sync})
    );

    genvar gi;
    generate
        for (gi = 0; gi < NSTRAP; gi = gi + 1)
        begin : g_strap
            spsg_strap3 u_strap3
            (
                .i_sense_pullup(strap_pu_sync[gi]),
                .i_sense_pulldown(strap_pd_sync[gi]),
                .o_code(strap_code[gi])
            );
        end
    endgenerate

    // Sequencer: power-up and wake both wait for the straps to settle before sampling.
    always @*
    begin
        next_state = state;
        next_settle_count = settle_count;
        settle_done = 1'b0;
        case (state)
            ST_POWERUP, ST_WAKE:
            begin
                if (!power_down_n_sync)
                begin
                    next_settle_count = {CW{1'b0}};
                    if (state == ST_WAKE)
                    begin
                        next_state = ST_DOWN;
                    end
                end
                else if (settle_count == SETTLE_LAST)
                begin
                    settle_done = 1'b1;
                    next_settle_count = {CW{1'b0}};
                    next_state = ST_RUN;
                end
                else
                begin
                    next_settle_count = settle_count + 1'b1;
                end
            end
            ST_RUN:
            begin
                if (!power_down_n_sync)
                begin
                    next_state = ST_DOWN;
                end
            end
            ST_DOWN:
            begin
                if (power_down_n_sync)
                begin
                    next_state = ST_WAKE;
                end
            end
            default:
            begin
                next_state = ST_POWERUP;
                next_settle_count = {CW{1'b0}};
            end
        endcase
    end

    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= ST_POWERUP;
            settle_count <= {CW{1'b0}};
        end
        else
        begin
            state <= next_state;
            settle_count <= next_settle_count;
        end
    end

    // Control-port mode is fixed at the first power-up and kept across power-down.
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode <= `SPSG_RST_MODE;
            strap_1 <= `SPSG_RST_STRAP;
        end
        else if (settle_done && state == ST_POWERUP)
        begin
            strap_1 <= strap_code[1];
            if (strap_code[`SPSG_I2C_STRAP_INDEX] == `SPSG_I2C_STRAP_CODE)
            begin
                mode <= `SPSG_MODE_I2C;
            end
            else
            begin
                mode <= `SPSG_MODE_UART;
            end
        end
    end

    // Strap 0 and the immunity default are taken again at every wake.
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            strap_0 <= `SPSG_RST_STRAP;
            immunity <= `SPSG_RST_IMMUNITY;
        end
        else if (state == ST_DOWN)
        begin
            strap_0 <= `SPSG_RST_STRAP;
            immunity <= `SPSG_RST_IMMUNITY;
        end
        else if (settle_done)
        begin
            strap_0 <= strap_code[0];
            immunity <= shared_sync;
        end
        else if (state == ST_RUN && i_immunity_wr_en)
        begin
            immunity <= i_immunity_wr_data;
        end
    end

    // Mirror and fault are registered so the pins never glitch on the state decode.
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mirror <= 1'b0;
            fault <= 1'b0;
            powered_down <= 1'b1;
        end
        else
        begin
            powered_down <= (next_state == ST_DOWN) || (next_state == ST_POWERUP && !power_down_n_sync);
            if (state == ST_RUN && power_down_n_sync)
            begin
                mirror <= i_remote_general_in;
                fault <= fault_sync_0 | fault_sync_1;
            end
            else
            begin
                mirror <= 1'b0;
                fault <= 1'b0;
            end
        end
    end

    assign o_power_down = powered_down;
    assign o_ready = (state == ST_RUN);
    assign o_config_strap_0 = strap_0;
    assign o_config_strap_1 = strap_1;
    assign o_control_mode = mode;
    assign o_high_immunity_bit = immunity;

    // Open-drain pins only ever drive low; the enable decides whether they pull.
    assign o_ctrl_pin0 = 1'b0;
    assign o_ctrl_pin1 = 1'b0;
    assign o_ctrl_pin0_oe = (mode == `SPSG_MODE_I2C) && i_i2c_sda_pull_low;
    assign o_ctrl_pin1_oe = (mode == `SPSG_MODE_I2C) ? i_i2c_scl_pull_low : !i_uart_tx;
    assign o_uart_rx = (mode == `SPSG_MODE_UART) ? pin0_sync : 1'b1;
    assign o_i2c_sda = (mode == `SPSG_MODE_I2C) ? pin0_sync : 1'b1;
    assign o_i2c_scl = (mode == `SPSG_MODE_I2C) ? pin1_sync : 1'b1;

    assign o_line_fault_n = 1'b0;
    assign o_line_fault_n_oe = fault;

    // The shared pin is only an input while straps are sampled or the block is down.
    assign o_shared_pin = mirror;
    assign o_shared_pin_oe = (state == ST_RUN);
    assign o_remote_mirror_out = mirror;
endmodule
`default_nettype wire

// ---- pkg/spsg_regs.vh ----
// Constants for the power-down, strap latching and mirror-output sequencer.
// Behaviour
// - Low power_down_n puts the device in power-down; high releases it.
// - Control-port UART or I2C choice comes from straps sampled at power-up, then held.
// - Control-port pins are open-drain only; the board supplies pull-ups.
// - UART selection: first pin is receive input, second pin transmit output.
// - I2C selection: pins are SDA and SCL of a master/slave I2C port.
// - Detected line fault pulls line_fault_n low, otherwise it is released.
// - While power_down_n is low, line_fault_n reads high.
// - Shared pin is strap input at power-up and wake, then mirror output.
// - high_immunity_bit default latches from the strap pin at power-up and wake.
// - After power-up, high_immunity_bit may be rewritten to another value.
// - In operation remote_mirror_out follows the remote general input level.
// - remote_mirror_out is low after power-up and during power-down.
// - Each configuration strap decodes as low, open or high.
// - config_strap_0 is sampled again at every wake from power-down.
`ifndef SPSG_REGS_VH
`define SPSG_REGS_VH

// Three-level strap codes.
`define SPSG_STRAP_LOW 2'h0
`define SPSG_STRAP_OPEN 2'h1
`define SPSG_STRAP_HIGH 2'h2

// Control-port modes.
`define SPSG_MODE_UART 1'h0
`define SPSG_MODE_I2C 1'h1

// Strap position that selects the I2C port, and which strap it is read from.
`define SPSG_I2C_STRAP_CODE `SPSG_STRAP_HIGH
`define SPSG_I2C_STRAP_INDEX 1

// Reset values.
`define SPSG_RST_MODE `SPSG_MODE_UART
`define SPSG_RST_STRAP `SPSG_STRAP_LOW
`define SPSG_RST_IMMUNITY 1'h0

// Strap settling time before sampling, and its cycle count at 10 ns.
`define SPSG_CLK_PERIOD_NS 10
`define SPSG_STRAP_SETTLE_NS 100
`define SPSG_STRAP_SETTLE_CYC ((`SPSG_STRAP_SETTLE_NS + `SPSG_CLK_PERIOD_NS - 1) / `SPSG_CLK_PERIOD_NS)

`endif

// ---- src/spsg_sync.v ----
// Two-flop synchroniser for a bus of independent pin levels.
`timescale 1ns/100ps
`default_nettype none
module spsg_sync
#(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
    // Clock and reset
    input wire i_clock,
    input wire i_reset_n,
    // Levels
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;

    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
        end
        else
        begin
            stage1 <= i_async;
            stage2 <= stage1;
        end
    end

    assign o_sync = stage2;
endmodule
`default_nettype wire

// ---- src/spsg_strap3.v ----
// Decoder of one three-level strap from its pulled-up and pulled-down sense levels.
`timescale 1ns/100ps
`default_nettype none
`include "spsg_regs.vh"
module spsg_strap3
(
    // Sense levels, already synchronised
    input wire i_sense_pullup,
    input wire i_sense_pulldown,
    // Decoded code
    output reg [1:0] o_code
);
    // A driven pin reads the same under both weak test pulls; an open pin follows them.
    always @*
    begin
        case ({i_sense_pullup, i_sense_pulldown})
            2'h3: o_code = `SPSG_STRAP_HIGH;
            2'h0: o_code = `SPSG_STRAP_LOW;
            default: o_code = `SPSG_STRAP_OPEN;
        endcase
    end
endmodule
`default_nettype wire

// ---- test/spsg_assertions.sv ----
// Port-level assertions for the power-down sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "spsg_regs.vh"
module spsg_chk
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Inputs
    input wire logic i_power_down_n,
    input wire logic i_uart_tx,
    input wire logic i_i2c_sda_pull_low,
    input wire logic i_i2c_scl_pull_low,
    input wire logic i_remote_general_in,
    input wire logic i_immunity_wr_en,
    input wire logic i_immunity_wr_data,
    // Outputs
    input wire logic o_power_down,
    input wire logic [1:0] o_config_strap_1,
    input wire logic o_control_mode,
    input wire logic o_ctrl_pin0,
    input wire logic o_ctrl_pin0_oe,
    input wire logic o_ctrl_pin1,
    input wire logic o_ctrl_pin1_oe,
    input wire logic o_line_fault_n,
    input wire logic o_line_fault_n_oe,
    input wire logic o_shared_pin,
    input wire logic o_shared_pin_oe,
    input wire logic o_remote_mirror_out,
    input wire logic o_high_immunity_bit,
    input wire logic o_ready
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    sequence s_pd_req;
        o_ready && !i_power_down_n;
    endsequence
    sequence s_wr;
        o_ready && i_immunity_wr_en ##1 o_ready;
    endsequence
    AST_PD_ENTER: assert property (s_pd_req |-> ##[1:5] o_power_down)
        else $error("power-down not entered");
    AST_PD_READY: assert property (o_power_down |-> !o_ready)
        else $error("ready while powered down");
    AST_FAULT_PD: assert property (o_power_down |-> !o_line_fault_n_oe)
        else $error("fault shown in power-down");
    AST_MIRROR_LOW: assert property (!$past(o_ready) |-> !o_remote_mirror_out)
        else $error("mirror high outside run");
    AST_MIRROR: assert property (o_ready && $past(o_ready) |-> o_remote_mirror_out == $past(i_remote_general_in))
        else $error("mirror does not follow");
    AST_SHARED: assert property (o_shared_pin_oe == o_ready && o_shared_pin == o_remote_mirror_out)
        else $error("shared pin role wrong");
    AST_IMM_WRITE: assert property (s_wr |-> o_high_immunity_bit == $past(i_immunity_wr_data))
        else $error("immunity write lost");
    AST_IMM_HOLD: assert property (o_ready && $past(o_ready && !i_immunity_wr_en) |-> $stable(o_high_immunity_bit))
        else $error("immunity changed alone");
    AST_MODE_HOLD: assert property ($past(o_ready) |-> $stable(o_control_mode) && $stable(o_config_strap_1))
        else $error("mode changed in run");
    AST_UART: assert property (o_control_mode == `SPSG_MODE_UART |-> !o_ctrl_pin0_oe && o_ctrl_pin1_oe == !i_uart_tx)
        else $error("uart pin drive wrong");
    AST_I2C: assert property (o_control_mode == `SPSG_MODE_I2C |->
        o_ctrl_pin0_oe == i_i2c_sda_pull_low && o_ctrl_pin1_oe == i_i2c_scl_pull_low)
        else $error("i2c pin drive wrong");
    AST_OPEN_DRAIN: assert property (!o_ctrl_pin0 && !o_ctrl_pin1 && !o_line_fault_n)
        else $error("open-drain pin driven high");
endmodule
bind spsg_top spsg_chk u_chk (.i_clock, .i_reset_n, .i_power_down_n, .i_uart_tx, .i_i2c_sda_pull_low,
    .i_i2c_scl_pull_low, .i_remote_general_in, .i_immunity_wr_en, .i_immunity_wr_data, .o_power_down,
    .o_config_strap_1, .o_control_mode, .o_ctrl_pin0, .o_ctrl_pin0_oe, .o_ctrl_pin1, .o_ctrl_pin1_oe,
    .o_line_fault_n, .o_line_fault_n_oe, .o_shared_pin, .o_shared_pin_oe, .o_remote_mirror_out,
    .o_high_immunity_bit, .o_ready);
`default_nettype wire

// ---- test/spsg_board.sv ----
// Board and remote-end model: pull-ups, strap resistors and remote pin drivers.
`timescale 1ns/100ps
`default_nettype none
module spsg_board
(
    // Device drivers
    input wire logic i_oe0,
    input wire logic i_oe1,
    input wire logic i_sh_oe,
    input wire logic i_sh,
    // Remote pulls and strap settings
    input wire logic i_pull0,
    input wire logic i_pull1,
    input wire logic i_him,
    input wire logic [1:0] i_lvl0,
    input wire logic [1:0] i_lvl1,
    // Resolved levels
    output logic o_pin0,
    output logic o_pin1,
    output logic o_sh,
    output logic [1:0] o_pu,
    output logic [1:0] o_pd
);
    // Lines rise only through the board pull-ups.
    assign o_pin0 = !(i_oe0 || i_pull0);
    assign o_pin1 = !(i_oe1 || i_pull1);
    // A released shared pin shows its strap; an open strap reads low.
    assign o_sh = i_sh_oe ? i_sh : i_him;
    // Codes 0 low, 1 open, 2 high, seen through weak pull tests.
    assign o_pu = {i_lvl1 != 2'h0, i_lvl0 != 2'h0};
    assign o_pd = {i_lvl1 == 2'h2, i_lvl0 == 2'h2};
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the power-down sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk, m_imm, exp_mir;
    logic rst_n = 1'b0, pd_n = 1'b1, tx = 1'b0, sda_l = 1'b0, scl_l = 1'b0, m0 = 1'b0, m1 = 1'b0;
    logic gen = 1'b0, wr = 1'b0, wd = 1'b0, r0 = 1'b0, r1 = 1'b0, immunity_strap_in = 1'b0;
    logic [1:0] lv0 = 2'h0, lv1 = 2'h0;
    logic [31:0] seed = 32'h61d2c8a9;
    logic q[$];
    wire p0, p1, sh, p0oe, p1oe, shoe, sho, pdo, mode, rx, sda, scl, lf, lfoe, mir, imm, rdy, p0o, p1o;
    wire [1:0] pu, pd, s0, s1;
    int err_count = 0, samples_checked = 0, cyc = 0, i, k;
    spsg_top #(.NSTRAP(2), .SETTLE_CYC(3)) u_dut (.i_clock(clk), .i_reset_n(rst_n), .i_power_down_n(pd_n),
        .o_power_down(pdo), .i_config_straps_pu(pu), .i_config_straps_pd(pd), .o_config_strap_0(s0),
        .o_config_strap_1(s1), .o_control_mode(mode), .i_ctrl_pin0(p0), .o_ctrl_pin0(p0o),
        .o_ctrl_pin0_oe(p0oe), .i_ctrl_pin1(p1), .o_ctrl_pin1(p1o), .o_ctrl_pin1_oe(p1oe), .i_uart_tx(tx),
        .o_uart_rx(rx), .i_i2c_sda_pull_low(sda_l), .i_i2c_scl_pull_low(scl_l), .o_i2c_sda(sda),
        .o_i2c_scl(scl), .i_line_monitor_in_0(m0), .i_line_monitor_in_1(m1), .o_line_fault_n(lf),
        .o_line_fault_n_oe(lfoe), .i_shared_pin(sh), .o_shared_pin(sho), .o_shared_pin_oe(shoe),
        .i_remote_general_in(gen), .o_remote_mirror_out(mir), .i_immunity_wr_en(wr),
        .i_immunity_wr_data(wd), .o_high_immunity_bit(imm), .o_ready(rdy));
    spsg_board u_board (.i_oe0(p0oe), .i_oe1(p1oe), .i_sh_oe(shoe), .i_sh(sho), .i_pull0(r0), .i_pull1(r1),
        .i_him(immunity_strap_in), .i_lvl0(lv0), .i_lvl1(lv1), .o_pin0(p0), .o_pin1(p1), .o_sh(sh), .o_pu(pu), .o_pd(pd));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_ready;
        k = 0;
        while (rdy !== 1'b1 && k < 100)
        begin
            tick(1);
            k++;
        end
        chk(rdy, 1'b1);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Random pin traffic; the synchronisers need two edges to show it.
    task automatic ctrl_port;
        repeat (8)
        begin
            seed = lfsr(seed);
            {tx, sda_l, scl_l, r0, r1} = seed[4:0];
            tick(3);
            if (mode === 1'b1)
            begin
                chk(sda, !(sda_l | r0));
                chk(scl, !(scl_l | r1));
                chk(rx, 1'b1);
            end
            else
            begin
                chk(rx, !r0);
                chk(p1, tx & !r1);
                chk({sda, scl}, 2'h3);
            end
            chk({p0o, p1o}, 2'h0);
        end
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            give_verdict();
        end
    end
    initial
    begin
        for (i = 0; i < 3; i++)
        begin
            lv1 = i[1:0];
            lv0 = 2'h2 - i[1:0];
            immunity_strap_in = i[0];
            rst_n = 1'b0;
            tick(8);
            rst_n = 1'b1;
            wait_ready();
            chk(s1, lv1);
            chk(s0, lv0);
            chk(mode, lv1 == 2'h2);
            chk(imm, immunity_strap_in);
            ctrl_port();
            $display("strap set %0d done", i);
        end
        repeat (20)
        begin
            seed = lfsr(seed);
            gen = seed[0];
            q.push_back(seed[0]);
            tick(1);
            exp_mir = q.pop_front();
            chk({mir, sho}, {exp_mir, exp_mir});
        end
        $display("mirror test done");
        m_imm = immunity_strap_in;
        wr = 1'b1;
        for (i = 0; i < 3; i++)
        begin
            m_imm = !m_imm;
            wd = m_imm;
            tick(1);
            chk(imm, m_imm);
        end
        wr = 1'b0;
        wd = !m_imm;
        tick(2);
        chk(imm, m_imm);
        $display("immunity test done");
        for (i = 0; i < 4; i++)
        begin
            {m1, m0} = i[1:0];
            tick(4);
            chk({lf, lfoe}, {1'b0, i != 0});
        end
        $display("fault test done");
        gen = 1'b1;
        pd_n = 1'b0;
        lv0 = 2'h1;
        lv1 = 2'h0;
        immunity_strap_in = 1'b1;
        tick(6);
        chk(pdo, 1'b1);
        chk(lfoe, 1'b0);
        chk(mir, 1'b0);
        chk(shoe, 1'b0);
        chk(imm, 1'b0);
        pd_n = 1'b1;
        wait_ready();
        chk(pdo, 1'b0);
        chk(s0, 2'h1);
        chk(s1, 2'h2);
        chk(mode, 1'b1);
        chk(imm, 1'b1);
        tick(4);
        chk(lfoe, 1'b1);
        $display("power-down test done");
        give_verdict();
    end
endmodule
`default_nettype wire
